// ===== sram_host_pkg.sv
package sram_host_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int WORDS = 1024;

    // Core clock
    localparam int CLK_PERIOD_NS = 50;

    // Fastest-grade pin timing, ns
    localparam int READ_CYCLE_MIN_NS = 120;
    localparam int ADDRESS_TO_DATA_MAX_NS = 120;
    localparam int OUTPUT_DRIVE_TO_DATA_MAX_NS = 50;
    localparam int DATA_HOLD_AFTER_ADDRESS_NS = 10;
    localparam int DESELECT_TO_STANDBY_MAX_NS = 60;
    localparam int WRITE_CYCLE_MIN_NS = 120;
    localparam int SELECT_TO_WRITE_END_MIN_NS = 90;
    localparam int WRITE_PULSE_MIN_NS = 70;
    localparam int WRITE_TO_FLOAT_MAX_NS = 40;
    localparam int POWER_UP_WAIT_NS = 500000;

    // Least times round up to whole cycles
    localparam int READ_WAIT_CYC =
        (ADDRESS_TO_DATA_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WRITE_PULSE_CYC =
        (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_WAIT_CYC =
        (WRITE_TO_FLOAT_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESELECT_CYC =
        (DESELECT_TO_STANDBY_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYC =
        (POWER_UP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 16;

    typedef enum logic [2:0] {
        ST_POWERUP = 3'b000,
        ST_IDLE    = 3'b001,
        ST_READ    = 3'b010,
        ST_WSETUP  = 3'b011,
        ST_WRITE   = 3'b100,
        ST_RECOVER = 3'b101
    } state_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } request_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } strobes_t;

endpackage

// ===== sram_host.sv
`timescale 1ns/1ns
module sram_host
    import sram_host_pkg::*;
#(
    parameter int POWER_UP_CYCLES = POWER_UP_CYC,
    parameter bit VERSION_B = 1'b0
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    // User request
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    output logic REQ_READY,
    output logic RD_VALID,
    output logic [DATA_W-1:0] RD_DATA,
    // Memory pins
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic MEM_CE_N,
    output logic MEM_OE_N,
    output logic MEM_WE_N,
    output logic MEM_VREF,
    input wire logic [DATA_W-1:0] MEM_DQ_IN,
    output logic [DATA_W-1:0] MEM_DQ_OUT,
    output logic MEM_DQ_OE
);

    // Elaboration checks: the sequencer serves only this geometry
    if (ADDR_W != 10 || DATA_W != 8
        || WORDS != (1 << ADDR_W)) begin : g_bad_geometry
        $error("Unsupported memory geometry");
    end
    if (POWER_UP_CYCLES < 1
        || POWER_UP_CYCLES >= (1 << CNT_W)) begin : g_bad_powerup
        $error("POWER_UP_CYCLES out of range");
    end
    // Select leads the strobe rise by the float wait plus the pulse
    if ((FLOAT_WAIT_CYC + WRITE_PULSE_CYC) * CLK_PERIOD_NS
        < SELECT_TO_WRITE_END_MIN_NS) begin : g_bad_select
        $error("Write select window too short");
    end
    if (WRITE_PULSE_CYC * CLK_PERIOD_NS
        < WRITE_PULSE_MIN_NS) begin : g_bad_pulse
        $error("Write pulse too short");
    end
    // Data is sampled this many cycles after select falls
    if ((READ_WAIT_CYC - 1) * CLK_PERIOD_NS
        < ADDRESS_TO_DATA_MAX_NS) begin : g_bad_read
        $error("Read wait too short");
    end

    state_t state;
    request_t req;
    strobes_t strb;
    logic [CNT_W-1:0] cnt;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    // Chip is selected through every access phase
    function automatic logic in_access(input state_t s);
        in_access = (s == ST_READ) || (s == ST_WSETUP)
                    || (s == ST_WRITE);
    endfunction

    // Last cycle of a timed phase
    function automatic logic phase_done(input state_t s, input state_t want,
                                        input logic [CNT_W-1:0] c);
        phase_done = (s == want) && (c == '0);
    endfunction

    assign strb = '{ce_n: MEM_CE_N, oe_n: MEM_OE_N, we_n: MEM_WE_N};

    // Sequencer and timers
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state <= ST_POWERUP;
            cnt <= cyc(POWER_UP_CYCLES);
            req <= '0;
        end else begin
            case (state)
                ST_POWERUP: begin
                    // No access until supply settles
                    if (cnt == '0)
                        state <= ST_IDLE;
                    else
                        cnt <= cnt - 1'b1;
                end
                ST_IDLE: begin
                    if (REQ_VALID) begin
                        req <= '{write: REQ_WRITE, addr: REQ_ADDR,
                                 wdata: REQ_WDATA};
                        // Address settles one cycle before select
                        if (REQ_WRITE) begin
                            state <= ST_WSETUP;
                            cnt <= cyc(FLOAT_WAIT_CYC);
                        end else begin
                            state <= ST_READ;
                            cnt <= cyc(READ_WAIT_CYC);
                        end
                    end
                end
                ST_READ: begin
                    if (cnt == '0) begin
                        state <= ST_RECOVER;
                        cnt <= cyc(DESELECT_CYC);
                    end else
                        cnt <= cnt - 1'b1;
                end
                ST_WSETUP: begin
                    // Device floats before host drives
                    if (cnt == '0) begin
                        state <= ST_WRITE;
                        // Extra last cycle holds data past the strobe
                        cnt <= cyc(WRITE_PULSE_CYC + 1);
                    end else
                        cnt <= cnt - 1'b1;
                end
                ST_WRITE: begin
                    if (cnt == '0) begin
                        state <= ST_RECOVER;
                        cnt <= cyc(DESELECT_CYC);
                    end else
                        cnt <= cnt - 1'b1;
                end
                ST_RECOVER: begin
                    if (cnt == '0)
                        state <= ST_IDLE;
                    else
                        cnt <= cnt - 1'b1;
                end
                default: state <= ST_POWERUP;
            endcase
        end
    end

    // Pin strobes, registered
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            MEM_CE_N <= 1'b1;
            MEM_OE_N <= 1'b1;
            MEM_WE_N <= 1'b1;
        end else begin
            MEM_CE_N <= !in_access(state);
            MEM_OE_N <= !(state == ST_READ);
            // Strobe high outside the write phase, so in every read
            // It rises a cycle before select; capture is on the strobe
            // edge while data is still driven
            MEM_WE_N <= !(state == ST_WRITE && !(cnt == '0));
        end
    end

    // Address loads at the take, a cycle ahead of select, and stays
    // put while the chip is selected
    always_ff @(posedge CORE_CLK) begin
        if (SRST)
            MEM_ADDR <= '0;
        else if (state == ST_IDLE && REQ_VALID)
            MEM_ADDR <= REQ_ADDR;
    end

    // Drive starts with the strobe and ends a cycle after it rises,
    // so the device never sees data change with the strobe
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            MEM_DQ_OUT <= '0;
            MEM_DQ_OE <= 1'b0;
        end else begin
            MEM_DQ_OUT <= req.wdata;
            MEM_DQ_OE <= (state == ST_WRITE);
        end
    end

    // Static level; registered so the pin cannot glitch
    always_ff @(posedge CORE_CLK) begin
        if (SRST)
            MEM_VREF <= 1'b0;
        else
            MEM_VREF <= VERSION_B;
    end

    // Sample at the last read cycle; static array needs no refresh
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            RD_VALID <= 1'b0;
            RD_DATA <= '0;
        end else begin
            RD_VALID <= phase_done(state, ST_READ, cnt)
                        && !strb.oe_n && strb.we_n;
            if (phase_done(state, ST_READ, cnt))
                RD_DATA <= MEM_DQ_IN;
        end
    end

    // Rises on the edge that enters idle, drops on the edge of a take
    always_ff @(posedge CORE_CLK) begin
        if (SRST)
            REQ_READY <= 1'b0;
        else
            REQ_READY <= phase_done(state, ST_RECOVER, cnt)
                         || phase_done(state, ST_POWERUP, cnt)
                         || (state == ST_IDLE && !REQ_VALID);
    end

endmodule // sram_host

// ===== sram_host_sva.sv
`timescale 1ns/1ns
module sram_host_chk
    import sram_host_pkg::*;
#(parameter int POWER_UP_CYCLES = 4, parameter bit VERSION_B = 1'b0) (
    input wire logic CORE_CLK, SRST, RD_VALID,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // Saturates so a long run never re-enters the wait
    logic [CNT_W-1:0] cnt;
    always_ff @(posedge CORE_CLK) begin
        if (SRST) cnt <= '0;
        else if (cnt != '1) cnt <= cnt + 1'b1;
    end
    sequence rd_go; $fell(MEM_OE_N); endsequence
    sequence rd_hold; (!MEM_OE_N && !MEM_CE_N)[*3]; endsequence
    sequence wr_go; $fell(MEM_WE_N); endsequence
    a_read_return: assert property (
        rd_go |-> rd_hold ##[1:6] RD_VALID) else $error("read short");
    a_read_we_high: assert property (
        !MEM_OE_N |-> MEM_WE_N) else $error("write in read");
    a_bus_no_clash: assert property (
        MEM_DQ_OE |-> MEM_OE_N && !MEM_CE_N) else $error("bus clash");
    a_we_width: assert property (
        wr_go |=> !MEM_WE_N) else $error("write pulse short");
    a_select_before_end: assert property (
        $rose(MEM_WE_N) |-> !$past(MEM_CE_N) && !$past(MEM_CE_N, 2))
        else $error("select short");
    a_write_spacing: assert property (
        wr_go |=> (!$fell(MEM_WE_N))[*2]) else $error("writes close");
    a_addr_setup: assert property (
        $fell(MEM_CE_N) |-> $stable(MEM_ADDR)) else $error("addr late");
    a_powerup_wait: assert property (
        cnt < POWER_UP_CYCLES |-> MEM_CE_N) else $error("early access");
endmodule // sram_host_chk

// ===== sram_dev_model.sv
`timescale 1ns/1ns
module sram_dev_model
    import sram_host_pkg::*;
(
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic MEM_CE_N, MEM_OE_N, MEM_WE_N,
    input wire logic [DATA_W-1:0] MEM_DQ_IN,
    output logic [DATA_W-1:0] dev_q,
    output logic drv
);
    logic [DATA_W-1:0] mem [WORDS];
    logic [DATA_W-1:0] late, last = '0, wd;
    logic [ADDR_W-1:0] wa;
    logic armed = 1'b0;
    assign #ADDRESS_TO_DATA_MAX_NS late = mem[MEM_ADDR];
    // Pins
    assign #(OUTPUT_DRIVE_TO_DATA_MAX_NS, WRITE_TO_FLOAT_MAX_NS)
        drv = !MEM_CE_N && !MEM_OE_N && MEM_WE_N;
    // Floating bus shows the inverse, not a stale value
    assign dev_q = drv ? late : ~last;
    always @* if (drv) last = late;
    always @(MEM_CE_N, MEM_WE_N, MEM_ADDR, MEM_DQ_IN) begin
        if (!MEM_CE_N && !MEM_WE_N) begin
            {wa, wd, armed} = {MEM_ADDR, MEM_DQ_IN, 1'b1};
        end else if (armed) begin
            mem[wa] = wd;
            armed = 1'b0;
        end
    end
endmodule // sram_dev_model

// ===== testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
n_errors++; $display("ERROR %0t bad value", $time); end end
module testbench;
    import sram_host_pkg::*;
    localparam int POWER_UP_CYCLES = 4;
    localparam bit VERSION_B = 1'b1;
    logic CORE_CLK = 1'b0, SRST = 1'b1, REQ_VALID = 1'b0, REQ_WRITE = 1'b0;
    logic [ADDR_W-1:0] REQ_ADDR = '0, MEM_ADDR;
    logic [DATA_W-1:0] REQ_WDATA = '0, RD_DATA, MEM_DQ_OUT, dev_q, MEM_DQ_IN;
    logic REQ_READY, RD_VALID, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_VREF;
    logic MEM_DQ_OE, drv;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    always #(CLK_PERIOD_NS / 2) CORE_CLK = ~CORE_CLK;
    // Contention shows as unknown rather than one side winning
    assign MEM_DQ_IN = (MEM_DQ_OE && drv) ? 'x : MEM_DQ_OE ? MEM_DQ_OUT : dev_q;
    sram_host #(.POWER_UP_CYCLES(POWER_UP_CYCLES), .VERSION_B(VERSION_B))
        i_dut (.*);
    sram_dev_model i_mem (.*);
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic issue(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(negedge CORE_CLK);
        {REQ_WRITE, REQ_ADDR, REQ_WDATA, REQ_VALID} = {w, a, d, 1'b1};
        while (REQ_READY !== 1'b1) @(negedge CORE_CLK);
        @(negedge CORE_CLK);
        REQ_VALID = 1'b0;
    endtask
    task automatic rd_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        issue(1'b0, a, '0);
        while (RD_VALID !== 1'b1) @(negedge CORE_CLK);
        `CHK(RD_DATA, e)
    endtask
    task automatic t_reset();
        repeat (12) @(negedge CORE_CLK);
        `CHK({REQ_READY, MEM_CE_N, MEM_DQ_OE}, 3'b010)
        SRST = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        `CHK({REQ_READY, MEM_CE_N, MEM_VREF}, {2'b01, VERSION_B})
    endtask
    task automatic t_fill();
        logic [ADDR_W-1:0] al [6] = '{10'h000, 10'h001, 10'h155, 10'h2aa,
            10'h3fe, 10'h3ff};
        foreach (al[i]) issue(1'b1, al[i], al[i][7:0] ^ 8'ha5);
        foreach (al[i]) rd_chk(al[i], al[i][7:0] ^ 8'ha5);
    endtask
    task automatic t_overwrite();
        issue(1'b1, 10'h0f0, 8'h11);
        issue(1'b1, 10'h0f0, 8'hee);
        rd_chk(10'h0f0, 8'hee);
    endtask
    task automatic t_busy();
        issue(1'b0, 10'h155, '0);
        @(negedge CORE_CLK);
        {REQ_WRITE, REQ_VALID} = 2'b11;
        @(negedge CORE_CLK);
        REQ_VALID = 1'b0;
        while (RD_VALID !== 1'b1) @(negedge CORE_CLK);
        `CHK(RD_DATA, 8'hf0)
        rd_chk(10'h155, 8'hf0);
    endtask
    initial begin
        t_reset();
        t_fill();
        t_overwrite();
        t_busy();
        end_sim();
    end
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 3000) begin
            $display("ERROR %0t timeout", $time);
            n_errors++;
            end_sim();
        end
    end
endmodule // testbench
bind sram_host sram_host_chk #(.POWER_UP_CYCLES(POWER_UP_CYCLES),
    .VERSION_B(VERSION_B)) i_chk (.*);
